// File: dv/rfd_host_model.sv
// Host model that writes 24-bit control words over the three-wire serial pins
`timescale 1ns/1ps

module rfd_host_model (
    // Clock
    input wire logic ref_clk_i,
    // Serial pins
    output logic ser_clk_o,
    output logic ser_data_o,
    output logic ser_le_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // Idle levels: the serial clock stands low outside frames
    initial begin
        ser_clk_o = 1'b0;
        ser_data_o = 1'b0;
        ser_le_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One frame, first bit out is bit 23; each level held three cycles so that
    // the receiver's two-stage synchroniser never loses a pulse
    task automatic write_word(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            @(posedge ref_clk_i);
            ser_clk_o <= 1'b0;
            ser_data_o <= w[i];
            repeat (3) @(posedge ref_clk_i);
            ser_clk_o <= 1'b1;
            repeat (2) @(posedge ref_clk_i);
        end
        @(posedge ref_clk_i);
        ser_clk_o <= 1'b0;
        ser_le_o <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        ser_le_o <= 1'b0;
        // Released data line shows the inverse, never a stale value
        ser_data_o <= ~ser_data_o;
    endtask
endmodule // rfd_host_model

// File: dv/tb.sv
// Self-checking testbench of the RF feedback and fast-acquisition control block
`timescale 1ns/1ps
`include "rfd_cfg.svh"

module tb;
    import rfd_pkg::*;

    logic ref_clk = 1'b0;
    logic rst_n;
    logic pfd_event;
    logic ser_clk, ser_data, ser_le;
    logic [14:0] count, hb_count, b;
    logic illegal, hb_illegal, pd, hiz, pump, acq, oe;
    rfd_psc_t psc, hb_psc;
    logic [3:0] test_output_select;
    logic [20:0] ifw;
    logic [23:0] w;
    logic [11:0] v;
    logic [2:0] prev;
    int failures = 0;
    int cmp_count = 0;
    logic [14:0] bvals [4] = '{15'h0003, 15'h7FFF, 15'h0002, 15'h0010};
    logic [11:0] tvals [4] = '{12'h003, 12'h000, 12'h001, 12'h002};

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, host and the two band variants sharing the serial pins
    always #5 ref_clk = ~ref_clk;

    rfd_host_model host (.ref_clk_i(ref_clk), .ser_clk_o(ser_clk), .ser_data_o(ser_data),
        .ser_le_o(ser_le));

    rfd_ctrl #(.HIGH_BAND(1'b0)) dut (.ref_clk_i(ref_clk), .rstn_i(rst_n), .ser_clk_i(ser_clk),
        .ser_data_i(ser_data), .ser_le_i(ser_le), .pfd_event_i(pfd_event),
        .rf_binary_count_o(count), .rf_count_illegal_o(illegal), .rf_prescaler_select_o(psc),
        .rf_power_off_o(pd), .rf_pump_hiz_o(hiz), .rf_pump_high_o(pump),
        .rf_acquire_out_o(acq), .rf_acquire_oe_o(oe), .test_output_select_o(test_output_select),
        .if_reference_word_o(ifw));

    rfd_ctrl #(.HIGH_BAND(1'b1)) dut_hb (.ref_clk_i(ref_clk), .rstn_i(rst_n),
        .ser_clk_i(ser_clk), .ser_data_i(ser_data), .ser_le_i(ser_le), .pfd_event_i(pfd_event),
        .rf_binary_count_o(hb_count), .rf_count_illegal_o(hb_illegal),
        .rf_prescaler_select_o(hb_psc), .rf_power_off_o(), .rf_pump_hiz_o(), .rf_pump_high_o(),
        .rf_acquire_out_o(), .rf_acquire_oe_o(), .test_output_select_o(),
        .if_reference_word_o());

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Word write; written fields settle four edges after the load strobe, pump current and released-pump powerdown five
    task automatic wr(input logic [23:0] word);
        host.write_word(word);
        repeat (6) @(posedge ref_clk);
        #1;
    endtask

    // One detector event, then one edge for the loaded state to show
    task automatic pulse_event();
        @(posedge ref_clk);
        pfd_event <= 1'b1;
        @(posedge ref_clk);
        pfd_event <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Hang guard: a run that overstays counts as a mismatch
    initial begin
        repeat (100000) @(posedge ref_clk);
        failures++;
        $display("wrong value watchdog expected 0 seen 1");
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst_n = 1'b0;
        pfd_event = 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        chk("prescaler", PSC_8_9, psc);
        chk("hb_prescaler", PSC_16_17, hb_psc);
        chk("power_off", 0, pd);
        chk("acquire_oe", 0, oe);
        // Low-band count boundaries, the high-band top count, and both prescaler choices on both variants
        for (int k = 0; k < 4; k++) begin
            b = bvals[k];
            w = {1'b0, k[0], b, 4'h0, `RFD_ADDR_FEEDBACK};
            wr(w);
            chk("binary_count", b, count);
            chk("count_illegal", b < 3, illegal);
            chk("hb_binary_count", {1'b0, w[21:8]}, hb_count);
            chk("hb_count_illegal", w[21:8] < 3, hb_illegal);
            chk("prescaler", k[0] ? PSC_16_17 : PSC_8_9, psc);
            chk("hb_prescaler", k[0] ? PSC_32_33 : PSC_16_17, hb_psc);
        end
        // Unused codes must leave everything alone
        wr({21'h1FFFFF, 3'h5});
        chk("binary_count", 15'h0010, count);
        // Gain high, pump enabled, upper select bits
        wr({2'b11, 3'b001, 16'h0000, `RFD_ADDR_GAIN_HIZ});
        chk("pump_hiz", 0, hiz);
        chk("pump_high", 1, pump);
        w = {2'b01, 19'h2ABCD, `RFD_ADDR_IF_REF};
        wr(w);
        chk("test_select", 4'hD, test_output_select);
        chk("if_word", w[23:3], ifw);
        // Synchronous powerdown waits for a detector event
        wr({2'b10, 15'h0010, 4'h0, `RFD_ADDR_FEEDBACK});
        repeat (4) @(posedge ref_clk);
        #1;
        chk("power_off", 0, pd);
        pulse_event();
        chk("power_off", 1, pd);
        // Asynchronous: with the pump high impedance, powerup needs no event
        wr({2'b11, 3'b011, 16'h0000, `RFD_ADDR_GAIN_HIZ});
        chk("pump_hiz", 1, hiz);
        wr({2'b00, 15'h0010, 4'h0, `RFD_ADDR_FEEDBACK});
        chk("power_off", 0, pd);
        wr({2'b11, 3'b000, 16'h0000, `RFD_ADDR_GAIN_HIZ});
        chk("pump_high", 0, pump);
        // Fixed modes, each held off until the next event
        prev = 3'b000;
        for (int k = 0; k < 4; k++) begin
            v = tvals[k];
            wr({9'h000, v, `RFD_ADDR_TIMEOUT});
            chk("mode_before_event", prev, {oe, acq & oe, pump});
            pulse_event();
            prev = {v != 0, v == 3, v == 1};
            chk("mode_pins", prev, {oe, acq & oe, pump});
        end
        wr({2'b11, 3'b001, 16'h0000, `RFD_ADDR_GAIN_HIZ});
        chk("pump_high", 1, pump);
        // Automatic mode at both ends of its range, gain high so the drop shows
        for (int k = 0; k < 2; k++) begin
            v = k ? 12'hFFF : 12'h004;
            wr({9'h000, v, `RFD_ADDR_TIMEOUT});
            pulse_event();
            chk("auto_start", 3'b101, {oe, acq, pump});
            repeat (v - 1) pulse_event();
            chk("auto_hold", 3'b101, {oe, acq, pump});
            pulse_event();
            chk("auto_done", 2'b00, {oe, pump});
        end
        give_verdict();
    end
endmodule // tb

// File: hdl/rfd_acq_timer.sv
// Fast-acquisition timeout counter, pin driver and pump-gain override
`timescale 1ns/1ps
`include "rfd_cfg.svh"

module rfd_acq_timer
    import rfd_pkg::*;
#(
    parameter int TOC_W = `RFD_TOC_W
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Setting and events
    input wire logic write_i,
    input wire logic [TOC_W-1:0] setting_i,
    input wire logic pfd_event_i,
    input wire logic pump_gain_i,
    // Pin and pump
    output logic acquire_out_o,
    output logic acquire_oe_o,
    output logic pump_high_o,
    output rfd_pkg::rfd_acq_state_t state_o
);
    logic pend_q;
    logic [TOC_W-1:0] pend_val_q;
    logic [TOC_W-1:0] count_q;
    logic [TOC_W-1:0] count_d;
    logic load;
    rfd_acq_state_t state_d;

    // A setting waits for the next detector event; a write in that cycle stays pending
    assign load = pfd_event_i & pend_q;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pend_q <= 1'b0;
            pend_val_q <= `RFD_RST_TOC;
        end else if (write_i) begin
            pend_q <= 1'b1;
            pend_val_q <= setting_i;
        end else if (load) begin
            pend_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state: mode chosen by the latched value, auto mode counts events
    always_comb begin
        state_d = state_o;
        count_d = count_q;
        if (load) begin
            count_d = pend_val_q;
            case (pend_val_q)
                `RFD_TOC_OFF: state_d = ACQ_OFF;
                `RFD_TOC_MANUAL: state_d = ACQ_MANUAL;
                `RFD_TOC_GPO_LO: state_d = ACQ_GPO_LO;
                `RFD_TOC_GPO_HI: state_d = ACQ_GPO_HI;
                default: state_d = ACQ_AUTO;
            endcase
        end else if (pfd_event_i && state_o == ACQ_AUTO) begin
            count_d = count_q - `RFD_TOC_LAST;
            if (count_q == `RFD_TOC_LAST) begin
                state_d = ACQ_DONE;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_o <= ACQ_OFF;
            count_q <= `RFD_RST_TOC;
        end else begin
            state_o <= state_d;
            count_q <= count_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin and pump follow the next state so they line up with state_o
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            acquire_out_o <= 1'b0;
            acquire_oe_o <= 1'b0;
            pump_high_o <= 1'b0;
        end else begin
            case (state_d)
                ACQ_MANUAL, ACQ_AUTO: begin
                    acquire_out_o <= 1'b0;
                    acquire_oe_o <= 1'b1;
                    pump_high_o <= 1'b1;
                end
                ACQ_GPO_LO: begin
                    acquire_out_o <= 1'b0;
                    acquire_oe_o <= 1'b1;
                    pump_high_o <= pump_gain_i;
                end
                ACQ_GPO_HI: begin
                    acquire_out_o <= 1'b1;
                    acquire_oe_o <= 1'b1;
                    pump_high_o <= pump_gain_i;
                end
                ACQ_DONE: begin
                    // Timed out: pin released and current held at the low step
                    acquire_out_o <= 1'b0;
                    acquire_oe_o <= 1'b0;
                    pump_high_o <= 1'b0;
                end
                default: begin
                    acquire_out_o <= 1'b0;
                    acquire_oe_o <= 1'b0;
                    pump_high_o <= pump_gain_i;
                end
            endcase
        end
    end

endmodule // rfd_acq_timer

// File: hdl/rfd_cfg.svh
// Bit positions, register codes and reset values of the RF feedback control words
`ifndef RFD_CFG_SVH
`define RFD_CFG_SVH

// Serial word layout
`define RFD_WORD_W 24
`define RFD_ADDR_MSB 2
`define RFD_ADDR_GAIN_HIZ 3'h0
`define RFD_ADDR_FEEDBACK 3'h1
`define RFD_ADDR_TIMEOUT 3'h2
`define RFD_ADDR_IF_REF 3'h3

// Gain / high-impedance word
`define RFD_GAIN_BIT 19
`define RFD_HIZ_BIT 20
`define RFD_SEL_HI_LSB 22

// Feedback divider word
`define RFD_B_MSB 21
`define RFD_B15_LSB 7
`define RFD_B14_LSB 8
`define RFD_B_W 15
`define RFD_B_MIN 15'h0003
`define RFD_PSC_BIT 22
`define RFD_PD_BIT 23

// Timeout word
`define RFD_TOC_MSB 14
`define RFD_TOC_LSB 3
`define RFD_TOC_W 12
`define RFD_TOC_OFF 12'h000
`define RFD_TOC_MANUAL 12'h001
`define RFD_TOC_GPO_LO 12'h002
`define RFD_TOC_GPO_HI 12'h003
`define RFD_TOC_LAST 12'h001

// Reference-control word
`define RFD_SEL_LO_LSB 22
`define RFD_IF_W 21

// Reset values
`define RFD_RST_WORD 24'h000000
`define RFD_RST_TOC 12'h000

`endif

// File: hdl/rfd_ctrl.sv
// RF feedback divider, powerdown and fast-acquisition control top level
`timescale 1ns/1ps
`include "rfd_cfg.svh"

// Summary of operation
// - Low bands: 15-bit feedback count in bits 21:7, values 3..32767.
// - High band: 14-bit feedback count in bits 21:8, values 3..16383.
// - Low bands: prescaler bit 22 picks 8/9 at 0, 16/17 at 1.
// - High band: prescaler bit 22 picks 16/17 at 0, 32/33 at 1.
// - Bit 23 of the feedback word: 0 keeps the loop on, 1 powers down.
// - Powerdown is synchronous or asynchronous depending on the pump high-impedance bit.
// - Timeout is 12 bits in bits 14:3, other data bits zero.
// - Timeout 0: no fast acquisition, pin released, pump follows gain bit.
// - Timeout 1: pin driven low, pump forced to 4 mA.
// - Timeout 2: pin driven low as output, pump follows gain bit.
// - Timeout 3: pin driven high as output, pump follows gain bit.
// - Timeout 4..4095: pin low and 4 mA for that many events, then release.
// - New timeout takes effect at the next detector event only.
// - Code 3 word carries the lower two output-select bits and IF fields.
// - Gain bit picks 1 mA at 0, 4 mA at 1 when not forced.
// - Pump high-impedance bit switches the pump output at once.
module rfd_ctrl
    import rfd_pkg::*;
#(
    parameter bit HIGH_BAND = 1'b0
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Three-wire serial pins
    input wire logic ser_clk_i,
    input wire logic ser_data_i,
    input wire logic ser_le_i,
    // Phase-detector event from the RF loop
    input wire logic pfd_event_i,
    // Feedback divider controls
    output logic [`RFD_B_W-1:0] rf_binary_count_o,
    output logic rf_count_illegal_o,
    output rfd_pkg::rfd_psc_t rf_prescaler_select_o,
    output logic rf_power_off_o,
    // Charge pump controls
    output logic rf_pump_hiz_o,
    output logic rf_pump_high_o,
    // Acquisition pin
    output logic rf_acquire_out_o,
    output logic rf_acquire_oe_o,
    // Other fields
    output logic [3:0] test_output_select_o,
    output logic [`RFD_IF_W-1:0] if_reference_word_o
);
    import rfd_pkg::*;

    logic word_valid;
    logic [`RFD_WORD_W-1:0] word;
    logic wr_gain_hiz;
    logic wr_feedback;
    logic wr_timeout;
    logic wr_if_ref;
    logic pump_gain_q;
    logic power_req_q;
    logic [1:0] sel_hi_q;
    logic [1:0] sel_lo_q;
    logic acq_out;
    logic acq_oe;
    logic pump_high;
    rfd_acq_state_t acq_state;

    // Field extraction depends on the band variant
    function automatic logic [`RFD_B_W-1:0] rfd_b_field(input logic [`RFD_WORD_W-1:0] w);
        if (HIGH_BAND) begin
            return {1'b0, w[`RFD_B_MSB:`RFD_B14_LSB]};
        end else begin
            return w[`RFD_B_MSB:`RFD_B15_LSB];
        end
    endfunction

    function automatic rfd_psc_t rfd_psc_field(input logic sel);
        if (HIGH_BAND) begin
            return sel ? PSC_32_33 : PSC_16_17;
        end else begin
            return sel ? PSC_16_17 : PSC_8_9;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Serial receiver
    rfd_ser_rx #(
        .WORD_W(`RFD_WORD_W)
    ) u_rx (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .ser_clk_i(ser_clk_i),
        .ser_data_i(ser_data_i),
        .ser_le_i(ser_le_i),
        .word_valid_o(word_valid),
        .word_o(word)
    );

    // Address decode; codes outside this block are ignored here
    always_comb begin
        wr_gain_hiz = 1'b0;
        wr_feedback = 1'b0;
        wr_timeout = 1'b0;
        wr_if_ref = 1'b0;
        if (!word_valid) begin
            wr_gain_hiz = 1'b0;
        end else if (word[`RFD_ADDR_MSB:0] == `RFD_ADDR_GAIN_HIZ) begin
            wr_gain_hiz = 1'b1;
        end else if (word[`RFD_ADDR_MSB:0] == `RFD_ADDR_FEEDBACK) begin
            wr_feedback = 1'b1;
        end else if (word[`RFD_ADDR_MSB:0] == `RFD_ADDR_TIMEOUT) begin
            wr_timeout = 1'b1;
        end else if (word[`RFD_ADDR_MSB:0] == `RFD_ADDR_IF_REF) begin
            wr_if_ref = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Gain and high-impedance bits; the pump switch acts as soon as written
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pump_gain_q <= 1'b0;
            rf_pump_hiz_o <= 1'b0;
            sel_hi_q <= 2'h0;
        end else if (wr_gain_hiz) begin
            pump_gain_q <= word[`RFD_GAIN_BIT];
            rf_pump_hiz_o <= word[`RFD_HIZ_BIT];
            sel_hi_q <= word[`RFD_SEL_HI_LSB+1:`RFD_SEL_HI_LSB];
        end
    end

    // Feedback divider word
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rf_binary_count_o <= '0;
            rf_count_illegal_o <= 1'b1;
            rf_prescaler_select_o <= HIGH_BAND ? PSC_16_17 : PSC_8_9;
            power_req_q <= 1'b0;
        end else if (wr_feedback) begin
            rf_binary_count_o <= rfd_b_field(word);
            // Counts below three are flagged, not corrected
            rf_count_illegal_o <= rfd_b_field(word) < `RFD_B_MIN;
            rf_prescaler_select_o <= rfd_psc_field(word[`RFD_PSC_BIT]);
            power_req_q <= word[`RFD_PD_BIT];
        end
    end

    // With the pump released the powerdown follows at once, else at the next event
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rf_power_off_o <= 1'b0;
        end else if (rf_pump_hiz_o || pfd_event_i) begin
            rf_power_off_o <= power_req_q;
        end
    end

    // Reference-control word: only the select bits and raw fields are kept
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sel_lo_q <= 2'h0;
            if_reference_word_o <= '0;
        end else if (wr_if_ref) begin
            sel_lo_q <= word[`RFD_SEL_LO_LSB+1:`RFD_SEL_LO_LSB];
            if_reference_word_o <= word[`RFD_IF_W+`RFD_TOC_LSB-1:`RFD_TOC_LSB];
        end
    end

    // Two registers written by two words; one process each keeps a single driver per variable
    assign test_output_select_o = {sel_hi_q, sel_lo_q};

    ////////////////////////////////////////////////////////////////////////////////
    // Fast-acquisition timer; unused timeout bits are dropped
    rfd_acq_timer #(
        .TOC_W(`RFD_TOC_W)
    ) u_timer (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .write_i(wr_timeout),
        .setting_i(word[`RFD_TOC_MSB:`RFD_TOC_LSB]),
        .pfd_event_i(pfd_event_i),
        .pump_gain_i(pump_gain_q),
        .acquire_out_o(acq_out),
        .acquire_oe_o(acq_oe),
        .pump_high_o(pump_high),
        .state_o(acq_state)
    );

    assign rf_acquire_out_o = acq_out;
    assign rf_acquire_oe_o = acq_oe;
    assign rf_pump_high_o = pump_high;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);

    sequence s_fb_write;
        wr_feedback;
    endsequence

    sequence s_hiz_write;
        wr_gain_hiz;
    endsequence

    sequence s_ref_write;
        wr_if_ref;
    endsequence

    AST_B_FIELD: assert property (s_fb_write |=>
        rf_binary_count_o == rfd_b_field($past(word)))
        else $error("feedback count not taken from written word");

    AST_B_ILLEGAL: assert property (s_fb_write |=>
        rf_count_illegal_o == ($past(rfd_b_field(word)) < `RFD_B_MIN))
        else $error("illegal count flag wrong");

    AST_PSC: assert property (s_fb_write |=>
        rf_prescaler_select_o == rfd_psc_field($past(word[`RFD_PSC_BIT])))
        else $error("prescaler ratio does not match select bit");

    AST_PD_ASYNC: assert property ((s_fb_write ##0 rf_pump_hiz_o) |=> ##1
        rf_power_off_o == $past(word[`RFD_PD_BIT], 2))
        else $error("asynchronous powerdown not applied");

    AST_PD_SYNC: assert property ($changed(rf_power_off_o) |->
        $past(rf_pump_hiz_o) || $past(pfd_event_i))
        else $error("synchronous powerdown changed without an event");

    AST_HIZ: assert property (s_hiz_write |=>
        rf_pump_hiz_o == $past(word[`RFD_HIZ_BIT]))
        else $error("pump high impedance bit not applied");

    AST_SEL_LO: assert property (s_ref_write |=>
        test_output_select_o[1:0] == $past(word[`RFD_SEL_LO_LSB+1:`RFD_SEL_LO_LSB]))
        else $error("lower output select bits not taken");

    AST_LATCH: assert property ($changed(acq_state) |-> $past(pfd_event_i))
        else $error("timeout mode changed without a detector event");

    AST_MODE_OFF: assert property ((acq_state == ACQ_OFF) |->
        !rf_acquire_oe_o && rf_pump_high_o == $past(pump_gain_q))
        else $error("timeout zero drives pin or overrides gain");

    AST_MODE_MANUAL: assert property ((acq_state == ACQ_MANUAL) |->
        rf_acquire_oe_o && !rf_acquire_out_o && rf_pump_high_o)
        else $error("manual mode pin or pump wrong");

    AST_MODE_LO: assert property ((acq_state == ACQ_GPO_LO) |->
        rf_acquire_oe_o && !rf_acquire_out_o && rf_pump_high_o == $past(pump_gain_q))
        else $error("low output mode wrong");

    AST_MODE_HI: assert property ((acq_state == ACQ_GPO_HI) |->
        rf_acquire_oe_o && rf_acquire_out_o && rf_pump_high_o == $past(pump_gain_q))
        else $error("high output mode wrong");

    AST_AUTO_END: assert property ((acq_state == ACQ_AUTO) ##1
        (acq_state == ACQ_DONE) |-> !rf_acquire_oe_o && !rf_pump_high_o)
        else $error("timed-out state keeps pin or high current");

    AST_AUTO_RUN: assert property ((acq_state == ACQ_AUTO) |->
        rf_acquire_oe_o && !rf_acquire_out_o && rf_pump_high_o)
        else $error("auto mode pin or pump wrong");

    AST_SEL_HI: assert property (s_hiz_write |=>
        test_output_select_o[3:2] == $past(word[`RFD_SEL_HI_LSB+1:`RFD_SEL_HI_LSB]))
        else $error("upper output select bits not taken");

    AST_GAIN: assert property (s_hiz_write |=>
        pump_gain_q == $past(word[`RFD_GAIN_BIT]))
        else $error("pump gain bit not taken");

    AST_IF_WORD: assert property (s_ref_write |=>
        if_reference_word_o == $past(word[`RFD_IF_W+`RFD_TOC_LSB-1:`RFD_TOC_LSB]))
        else $error("reference-control fields not taken");

    AST_NO_DECODE: assert property (
        (word_valid && word[`RFD_ADDR_MSB:0] > `RFD_ADDR_IF_REF) |=> $stable(rf_binary_count_o))
        else $error("unused code changed the feedback count");

    AST_PD_FOLLOW: assert property (rf_pump_hiz_o |=>
        rf_power_off_o == $past(power_req_q))
        else $error("asynchronous powerdown does not follow the stored bit");

    AST_PD_EVENT: assert property (pfd_event_i |=>
        rf_power_off_o == $past(power_req_q))
        else $error("powerdown bit not applied at a detector event");

    AST_LOAD_WAIT: assert property ((wr_timeout && !pfd_event_i) |=>
        $stable(acq_state))
        else $error("timeout setting applied without a detector event");

    AST_AUTO_HOLD: assert property ((acq_state == ACQ_AUTO && !pfd_event_i) |=>
        acq_state == ACQ_AUTO)
        else $error("auto mode left without a detector event");

    AST_DONE_HOLD: assert property ((acq_state == ACQ_DONE && !pfd_event_i) |=>
        acq_state == ACQ_DONE)
        else $error("timed-out state left without a detector event");

    AST_DONE_LOW: assert property ((acq_state == ACQ_DONE) |->
        !rf_acquire_oe_o && !rf_pump_high_o)
        else $error("timed-out state drives pin or high current");

endmodule // rfd_ctrl

// File: hdl/rfd_pkg.sv
// Types shared by the RF feedback and fast-acquisition control logic
package rfd_pkg;

    // Fast-acquisition timer states
    typedef enum logic [5:0] {
        ACQ_OFF    = 6'h01,
        ACQ_MANUAL = 6'h02,
        ACQ_GPO_LO = 6'h04,
        ACQ_GPO_HI = 6'h08,
        ACQ_AUTO   = 6'h10,
        ACQ_DONE   = 6'h20
    } rfd_acq_state_t;

    // Dual-modulus prescaler ratio chosen
    typedef enum logic [1:0] {
        PSC_8_9   = 2'h0,
        PSC_16_17 = 2'h1,
        PSC_32_33 = 2'h2
    } rfd_psc_t;

endpackage

// File: hdl/rfd_ser_rx.sv
// Three-wire serial receiver: pin synchronisers, shifter and load strobe
`timescale 1ns/1ps
`include "rfd_cfg.svh"

module rfd_ser_rx #(
    parameter int WORD_W = `RFD_WORD_W
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Serial pins
    input wire logic ser_clk_i,
    input wire logic ser_data_i,
    input wire logic ser_le_i,
    // Received word
    output logic word_valid_o,
    output logic [WORD_W-1:0] word_o
);
    logic [2:0] pin_raw;
    logic [2:0] pin_sync;
    logic [2:0] pin_prev_q;
    logic clk_rise;
    logic le_rise;
    logic [WORD_W-1:0] shift_q;

    assign pin_raw = {ser_le_i, ser_data_i, ser_clk_i};

    ////////////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers; the first stage feeds only the second
    generate
        for (genvar i = 0; i < 3; i++) begin : g_sync
            logic meta_q;
            logic sync_q;
            always_ff @(posedge ref_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= pin_raw[i];
                    sync_q <= meta_q;
                end
            end
            assign pin_sync[i] = sync_q;
        end
    endgenerate

    // Edge detection works on the synchronised copies only
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_prev_q <= 3'h0;
        end else begin
            pin_prev_q <= pin_sync;
        end
    end

    assign clk_rise = pin_sync[0] & ~pin_prev_q[0];
    assign le_rise = pin_sync[2] & ~pin_prev_q[2];

    ////////////////////////////////////////////////////////////////////////////////
    // Data enters MSB first; the last bit shifted is the address LSB
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shift_q <= '0;
        end else if (clk_rise) begin
            shift_q <= {shift_q[WORD_W-2:0], pin_sync[1]};
        end
    end

    // Load strobe hands the whole word over in one cycle
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            word_valid_o <= 1'b0;
            word_o <= '0;
        end else begin
            word_valid_o <= le_rise;
            if (le_rise) begin
                word_o <= shift_q;
            end
        end
    end

endmodule // rfd_ser_rx
